/* File: rtl/cem_pkg.sv */
package cem_pkg;
  // register map on the documented register port
  localparam logic [7:0] CEM_AFE_SETUP_ADDR  = 8'h41;
  localparam logic [7:0] CEM_FILT_CFG_ADDR   = 8'h43;
  localparam logic [7:0] CEM_AFE_SETUP_RST   = 8'h00;
  localparam logic [7:0] CEM_FILT_CFG_RST    = 8'h00;
  localparam logic [7:0] CEM_UNMAPPED_RD     = 8'h00;
  // field positions
  localparam int CEM_FFSC_LSB  = 6; // first_filter_sample_count 7:6
  localparam int CEM_CCS_LSB   = 0; // charge_current_select 5:0
  localparam int CEM_CTS_LSB   = 5; // charge_time_select 7:5
  localparam int CEM_NUM_ELEC  = 3;
  localparam int CEM_ADC_W     = 10;
  localparam int CEM_SUM_W     = 16;
  // timing
  localparam int CEM_CLK_MHZ        = 100;
  localparam int CEM_CHG_BASE_NS    = 500;
  localparam int CEM_GND_HOLD_NS    = 500;
  localparam int CEM_CHG_BASE_CYC   = (CEM_CHG_BASE_NS * CEM_CLK_MHZ
                                       + 999) / 1000;
  localparam int CEM_GND_HOLD_CYC   = (CEM_GND_HOLD_NS * CEM_CLK_MHZ
                                       + 999) / 1000;
  localparam int CEM_TMR_W          = 12;
  // sample counts for codes 0..3
  localparam logic [5:0] CEM_FF_CNT0 = 6'h06;
  localparam logic [5:0] CEM_FF_CNT1 = 6'h0a;
  localparam logic [5:0] CEM_FF_CNT2 = 6'h12;
  localparam logic [5:0] CEM_FF_CNT3 = 6'h22;

  typedef enum {
    CEM_IDLE,
    CEM_GROUND,
    CEM_CHARGE,
    CEM_CONVERT,
    CEM_DISCHARGE
  } cem_phase_t;

  typedef struct packed {
    logic [5:0] cur_code;
    logic       chg_en;
    logic       dis_en;
    logic [2:0] elec_gnd_oe;
    logic [1:0] elec_sel;
  } cem_pad_t;

  typedef struct packed {
    logic                 valid;
    logic [1:0]           elec;
    logic [CEM_ADC_W-1:0] avg;
  } cem_result_t;
endpackage : cem_pkg

/* File: rtl/cem_measure.sv */
`timescale 1ns/1ns
// Contract
// (RULE1) ground the measured electrode before charging so it starts at zero
// (RULE2) hold all other electrodes at ground during a measurement
// (RULE3) after the charge time, take one 10-bit conversion as raw reading
// (RULE4) after conversion discharge the electrode at the charge current
// (RULE5) first filter sample count codes 0..3 select 6, 10, 18, 34
// (RULE6) charge current code zero disables charging entirely
// (RULE7) nonzero current code sets charge and discharge current in microamps
// (RULE8) charge time programmable from 500 ns to 32 us via time select
// (RULE9) time code 0 invalid, 1 is 0.5 us, each code doubles to 32 us
// (RULE10) first filter averages the selected number of raw conversions
// (RULE11) measure enabled electrodes one at a time in rotating order
module cem_measure (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic [7:0]                   reg_wdata,
  output      logic [7:0]                   reg_rdata,
  input  wire logic [2:0]                   elec_en,
  output      logic                         adc_start,
  input  wire logic                         adc_done,
  input  wire logic [cem_pkg::CEM_ADC_W-1:0] adc_data,
  output      cem_pkg::cem_pad_t            pad,
  output      cem_pkg::cem_result_t         result
);
  import cem_pkg::*;

  typedef struct packed {
    cem_phase_t               phase;
    logic [1:0]               elec;
    logic [CEM_TMR_W-1:0]     tmr;
    logic [5:0]               nsamp;
    logic [5:0]               target;
    logic [CEM_SUM_W-1:0]     sum;
    logic [7:0]               afe;
    logic [7:0]               fcfg;
    logic [7:0]               rdata;
    logic                     start;
    cem_result_t              res;
  } cem_state_t;

  cem_state_t s_q;
  cem_state_t s_d;

  logic [5:0]           cur_code;
  logic [2:0]           time_code;
  logic [1:0]           ff_code;
  logic [5:0]           ff_cnt;
  logic [CEM_TMR_W-1:0] chg_cyc;
  logic                 run_ok;
  logic [1:0]           next_elec;
  logic                 any_en;
  logic                 in_idle;
  logic                 in_ground;
  logic                 in_charge;
  logic                 in_discharge;
  logic [2:0]           gnd_oe;

  assign cur_code  = s_q.afe[CEM_CCS_LSB +: 6];
  assign ff_code   = s_q.afe[CEM_FFSC_LSB +: 2];
  assign time_code = s_q.fcfg[CEM_CTS_LSB +: 3];
  // zero current or invalid time both stop measuring
  assign run_ok    = (cur_code != 6'h00) && (time_code != 3'h0); // RULE6 RULE9
  assign any_en    = |elec_en;

  // phase decodes shared by the pad drive
  assign in_idle      = (s_q.phase == CEM_IDLE);
  assign in_ground    = (s_q.phase == CEM_GROUND);
  assign in_charge    = (s_q.phase == CEM_CHARGE);
  assign in_discharge = (s_q.phase == CEM_DISCHARGE);

  // per-pad ground switch; the measured pad floats only while it is
  // charged, converted or discharged, every other pad stays grounded
  for (genvar g = 0; g < CEM_NUM_ELEC; g++) begin : g_gnd
    assign gnd_oe[g] = (2'(g) != s_q.elec) // RULE2
                    || in_ground // RULE1
                    || in_idle;
  end

  // charge time doubles per code from 0.5 us; code 0 never gets here
  // because run_ok keeps the sequencer out of the charge phase
  always_comb begin
    chg_cyc = CEM_TMR_W'(CEM_CHG_BASE_CYC); // RULE8
    if (time_code != 3'h0) begin
      chg_cyc = CEM_TMR_W'(CEM_CHG_BASE_CYC) << (time_code - 3'h1); // RULE9
    end
  end

  // sample count table
  always_comb begin
    case (ff_code) // RULE5
      2'h0:    ff_cnt = CEM_FF_CNT0;
      2'h1:    ff_cnt = CEM_FF_CNT1;
      2'h2:    ff_cnt = CEM_FF_CNT2;
      default: ff_cnt = CEM_FF_CNT3;
    endcase
  end

  // next enabled electrode after the current one, wrapping
  always_comb begin
    logic [1:0] cand;
    cand      = s_q.elec;
    next_elec = s_q.elec;
    for (int i = 0; i < CEM_NUM_ELEC; i++) begin
      cand = (cand == 2'(CEM_NUM_ELEC - 1)) ? 2'h0 : cand + 2'h1;
      if (elec_en[cand] && next_elec == s_q.elec && !(i > 0 &&
          elec_en[next_elec] && next_elec != s_q.elec)) begin
        next_elec = cand; // RULE11
      end
    end
  end

  // next-state logic
  always_comb begin
    s_d           = s_q;
    s_d.start     = 1'b0;
    s_d.res.valid = 1'b0;
    // register writes; a write mid-measurement reaches the pad drive on the next cycle
    if (reg_wr && reg_addr == CEM_AFE_SETUP_ADDR) begin
      s_d.afe = reg_wdata;
    end
    if (reg_wr && reg_addr == CEM_FILT_CFG_ADDR) begin
      s_d.fcfg = reg_wdata;
    end
    // read data is registered; a read in the cycle of a write to the same
    // register still returns the old value
    case (reg_addr)
      CEM_AFE_SETUP_ADDR: s_d.rdata = s_q.afe;
      CEM_FILT_CFG_ADDR:  s_d.rdata = s_q.fcfg;
      default:            s_d.rdata = CEM_UNMAPPED_RD;
    endcase
    case (s_q.phase)
      // sample count latched here so a later write cannot skew the divisor
      CEM_IDLE: begin
        if (run_ok && any_en) begin
          s_d.elec   = next_elec; // RULE11
          s_d.nsamp  = 6'h00;
          s_d.target = ff_cnt; // RULE10
          s_d.sum    = '0;
          s_d.tmr    = CEM_TMR_W'(CEM_GND_HOLD_CYC);
          s_d.phase  = CEM_GROUND;
        end
      end
      // hold the pad at zero volts; a setting cleared meanwhile stops here
      CEM_GROUND: begin
        if (s_q.tmr > CEM_TMR_W'(1)) begin
          s_d.tmr = s_q.tmr - CEM_TMR_W'(1);
        end else if (!run_ok) begin
          s_d.phase = CEM_IDLE; // RULE6
        end else begin
          s_d.tmr   = chg_cyc; // RULE8
          s_d.phase = CEM_CHARGE;
        end
      end
      // timer runs even if the current is cleared, so phases stay aligned
      CEM_CHARGE: begin
        if (s_q.tmr > CEM_TMR_W'(1)) begin
          s_d.tmr = s_q.tmr - CEM_TMR_W'(1);
        end else begin
          s_d.start = 1'b1; // RULE3
          s_d.phase = CEM_CONVERT;
        end
      end
      // no time limit on the converter; done pulses elsewhere are dropped
      CEM_CONVERT: begin
        if (adc_done) begin
          s_d.sum   = s_q.sum + CEM_SUM_W'(adc_data); // RULE3 RULE10
          s_d.nsamp = s_q.nsamp + 6'h01;
          // same current for the same time returns the pad to zero
          s_d.tmr   = chg_cyc; // RULE4
          s_d.phase = CEM_DISCHARGE;
        end
      end
      // equal current for equal time brings the pad back to ground
      CEM_DISCHARGE: begin
        if (s_q.tmr > CEM_TMR_W'(1)) begin
          s_d.tmr = s_q.tmr - CEM_TMR_W'(1);
        end else if (s_q.nsamp >= s_q.target) begin
          s_d.res.valid = 1'b1;
          s_d.res.elec  = s_q.elec;
          s_d.res.avg   = CEM_ADC_W'(s_q.sum / CEM_SUM_W'(s_q.target));
          s_d.phase     = CEM_IDLE; // RULE11
        end else begin
          s_d.tmr   = CEM_TMR_W'(CEM_GND_HOLD_CYC); // RULE1
          s_d.phase = CEM_GROUND;
        end
      end
      default: s_d.phase = CEM_IDLE;
    endcase
  end

  // single state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q        <= '0;
      s_q.phase  <= CEM_IDLE;
      s_q.afe    <= CEM_AFE_SETUP_RST;
      s_q.fcfg   <= CEM_FILT_CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // pad drive decoded from phase; pads not selected stay grounded
  // a current cleared mid-charge cuts the source at once, trading one
  // short sample for never charging with a zero code
  always_comb begin
    pad             = '0;
    pad.elec_sel    = s_q.elec;
    pad.cur_code    = cur_code; // RULE7
    pad.chg_en      = in_charge && run_ok; // RULE6
    pad.dis_en      = in_discharge; // RULE4
    pad.elec_gnd_oe = gnd_oe; // RULE2
  end

  // outputs straight from the state register
  assign adc_start = s_q.start;
  assign reg_rdata = s_q.rdata;
  assign result    = s_q.res;
endmodule : cem_measure

/* File: bench/cem_sva.sv */
`timescale 1ns/1ns
module cem_sva (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_wr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              adc_start,
  input wire logic              adc_done,
  input wire cem_pkg::cem_pad_t pad
);
  import cem_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [2:0]  cts_q;
  logic [11:0] cnt_q;
  logic [11:0] t_exp;
  // shadow of the time code; the design reads it live
  assign t_exp = 12'd50 << (cts_q - 3'h1);
  always_ff @(posedge clk) begin
    if (srst)
      cts_q <= 3'h0;
    else if (reg_wr && reg_addr == 8'h43)
      cts_q <= reg_wdata[7:5];
    cnt_q <= (pad.chg_en || pad.dis_en) ? cnt_q + 12'h1 : 12'h0;
  end
  sequence s_charge_end;
    pad.chg_en ##1 !pad.chg_en;
  endsequence
  a_ground_first: assert property (
    $rose(pad.chg_en) |-> $past(pad.elec_gnd_oe) == 3'h7) else $error("gnd");
  a_others_grounded: assert property (
    (pad.chg_en || pad.dis_en) |-> pad.elec_gnd_oe == ~(3'h1 << pad.elec_sel))
    else $error("others");
  a_conv_after_chg: assert property (
    s_charge_end |-> ##[0:1] adc_start) else $error("no conv");
  a_dis_after_done: assert property (
    adc_done |=> pad.dis_en) else $error("no discharge");
  a_charge_len: assert property (
    $fell(pad.chg_en) |-> cnt_q == t_exp) else $error("charge time");
  a_dis_len: assert property (
    $fell(pad.dis_en) |-> cnt_q == t_exp) else $error("discharge time");
  a_cur_code: assert property (
    reg_wr && reg_addr == 8'h41 |=> pad.cur_code == $past(reg_wdata[5:0]))
    else $error("current code");
  a_one_phase: assert property (
    !(pad.chg_en && pad.dis_en)) else $error("overlap");
endmodule : cem_sva
bind cem_measure cem_sva u_sva (.clk, .srst, .reg_addr, .reg_wr,
  .reg_wdata, .adc_start, .adc_done, .pad);

/* File: bench/cem_adc_model.sv */
`timescale 1ns/1ns
module cem_adc_model (
  input  wire logic       clk,
  input  wire logic       adc_start,
  output      logic       adc_done,
  output      logic [9:0] adc_data
);
  // converter answers 1..4 cycles late; data is not held past done
  initial begin
    adc_done = 1'b0;
    adc_data = 10'h0;
    forever begin
      @(posedge clk);
      if (adc_start) begin
        repeat ($urandom_range(4, 1)) @(posedge clk);
        #1 adc_done = 1'b1;
        adc_data = 10'($urandom);
        @(posedge clk);
        #1 adc_done = 1'b0;
        adc_data = ~adc_data;
      end
    end
  end
endmodule : cem_adc_model

/* File: bench/capacitive_electrode_measure_test.sv */
`timescale 1ns/1ns
module capacitive_electrode_measure_test;
  import cem_pkg::*;
  logic        clk, srst, reg_wr, adc_start, adc_done;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, r;
  logic [2:0]  elec_en;
  logic [9:0]  adc_data;
  logic [15:0] sum;
  logic [1:0]  ffsc;
  cem_pad_t    pad;
  cem_result_t result;
  int          n_fail, checks, cyc, n_smp, n_st;
  logic [1:0]  last_el;
  cem_measure u_dut (.clk, .srst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata, .elec_en, .adc_start, .adc_done, .adc_data, .pad, .result);
  cem_adc_model u_adc (.clk, .adc_start, .adc_done, .adc_data);
  function automatic logic [15:0] nsmp(input logic [1:0] c);
    return (16'h4 << c) + 16'h2;
  endfunction : nsmp
  // next enabled pad after p, wrapping 0, 1, 2
  function automatic logic [1:0] nxt(input logic [1:0] p,
                                     input logic [2:0] en);
    logic [1:0] c;
    c = p;
    for (int i = 0; i < 3; i++) begin
      c = (c == 2'h2) ? 2'h0 : c + 2'h1;
      if (en[c]) return c;
    end
    return p;
  endfunction : nxt
  task automatic chk(input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #1 reg_wr = 1'b0;
    // strobe stays low across one edge so the next write never re-raises it
    @(posedge clk) #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    @(posedge clk) #1 r = reg_rdata;
  endtask : rd
  // one averaged result; stop afterwards and let the extra pick's ground end
  task automatic meas(input logic [1:0] f, input logic [2:0] c);
    ffsc = f;
    sum = 16'h0;
    n_smp = 0;
    elec_en = 3'($urandom_range(7, 1));
    wr(8'h43, {c, 5'h0});
    wr(8'h41, {f, 6'($urandom_range(63, 1))});
    while (result.valid !== 1'b1) @(posedge clk) #1;
    wr(8'h41, {f, 6'h0});
    repeat (100) @(posedge clk);
    #1;
  endtask : meas
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard; the full run needs about 90k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 97000) begin
      n_fail++;
      stop_test();
    end
  end
  // sample accumulator and result checks
  always @(posedge clk) begin
    n_st += adc_start;
    if (adc_done) sum += adc_data;
    n_smp += adc_done;
    if (result.valid === 1'b1) begin
      chk(16'(result.avg), sum / nsmp(ffsc));
      chk(16'(n_smp), nsmp(ffsc));
      chk(16'(elec_en[result.elec]), 16'h1);
      chk(16'(result.elec), 16'(nxt(last_el, elec_en)));
      // current is cleared one edge after the result, so one more pad is
      // picked and grounded before the block goes idle
      last_el = nxt(nxt(last_el, elec_en), elec_en);
    end
  end
  initial begin
    {reg_wr, reg_addr, reg_wdata, elec_en, last_el} = '0;
    srst = 1'b1;
    void'($urandom(80379));
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    rd(CEM_AFE_SETUP_ADDR);
    chk(16'(r), 16'(CEM_AFE_SETUP_RST));
    wr(8'h43, 8'($urandom));
    rd(8'h55);
    chk(16'(r), 16'(CEM_UNMAPPED_RD));
    rd(8'h43);
    chk(16'(r), 16'(reg_wdata));
    elec_en = 3'h7;
    wr(8'h41, 8'hc0);
    wr(8'h43, 8'h20);
    repeat (300) @(posedge clk);
    chk(16'(n_st), 16'h0);
    wr(8'h43, 8'h00);
    wr(8'h41, 8'h01);
    repeat (300) @(posedge clk);
    chk(16'(n_st), 16'h0);
    for (int f = 0; f < 4; f++) meas(2'(f), 3'h1);
    for (int c = 2; c < 8; c++) meas(2'h0, 3'(c));
    stop_test();
  end
endmodule : capacitive_electrode_measure_test
